/* hdl/rtcc_core.v */
// RTC control core: bus registers, disable gating, prescaler, timer chain and interrupts.
//
// Summary of operation
// - Prescaler mode switches and disable restart the divider, losing prescale accuracy.
// - Each source has own enable and request.
// - Software clears flags; set flag blocks new detection.
// - Disabled while central or local request active.
// - Disable sets status and gates kernel clock.
// - Clock gate register stays on bus clock.
// - Disabled: only clock gate register writable.
// - Ignore bit masks the central disable request.
// - Run bit zero stops, one counts.
// - Prescaler select inserts divider before timer.
// - Step down bit decrements timer, self clears.
// - Step up bit increments timer, self clears.
// - Access flag shows synchronous access possible.
// - Clock gate register always accessible.
// - Reset sets run and prescaler: 0003.
// - Prescale timer clocks 32-bit count and tick.
// - Sub node bit layout: pairs in bits 0-9.
// - Hardware set wins over software write.
// - Timer overflow raises request and reloads.
// - Prescaler divides reference by fixed factor.
`timescale 1ns/1ps
`include "rtcc_map.vh"
module rtcc_core #(
    parameter PRE_DIV = `RTCC_PRESCALE_DIV  // Fixed input prescaler factor.
) (
    // Clock and reset.
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    // Peripheral register port.
    input  wire [15:0] addr_i,
    input  wire        wr_i,
    input  wire        rd_i,
    input  wire [15:0] wdata_i,
    output reg  [15:0] rdata_o,
    // Reference clock input, sampled as a level.
    input  wire        ref_clk_i,
    // Central disable request from the system control register.
    input  wire        central_disable_request_i,
    // Alarm source pulses from the sub-timer logic, one per source.
    input  wire [3:0]  alarm_pulse_i,
    // Status and interrupt outputs.
    output wire        kernel_clk_en_o,
    output wire        disabled_status_o,
    output wire        overflow_tick_irq_o,
    output wire        rtc_irq_o
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam PW = 4;                         // Width of the prescale counter.
    reg  [15:0]   clk_gate_reg;                // Clock gate control bits.
    reg  [15:0]   run_ctrl_reg;                // Run, prescale and step bits.
    reg  [15:0]   rell_reg;                    // Count reload low word.
    reg  [15:0]   relh_reg;                    // Count reload high word.
    reg  [15:0]   pt_rel_reg;                  // Prescale timer reload.
    reg  [15:0]   pt_reg;                      // Prescale timer.
    reg  [15:0]   cnt_lo_reg;                  // Count low word.
    reg  [15:0]   cnt_hi_reg;                  // Count high word.
    reg  [PW-1:0] pre_cnt_reg;                 // Input prescaler counter.
    reg           ref_prev_reg;                // Previous synchronised reference.
    reg           tick_reg;                    // Overflow tick pulse.
    wire          ref_sync;                    // Synchronised reference clock.
    wire          central_sync;                // Synchronised central request.
    wire          ref_rise;                    // Reference rising edge.
    wire          pre_wrap;                    // Prescaler terminal count.
    wire          step_in;                     // Counting step into the timer.
    wire          disabled;                    // Module disabled.
    wire          wr_ok;                       // Kernel register write allowed.
    wire [15:0]   sn_rdata;                    // Sub node register image.
    wire          sn_wr;                       // Sub node write strobe.

    // Compare a bus address against a register offset.
    function hit;
        input [15:0] a;
        input [15:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    rtcc_sync2 u_ref_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .async_i   (ref_clk_i),
        .sync_o    (ref_sync)
    );
    rtcc_sync2 u_central_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .async_i   (central_disable_request_i),
        .sync_o    (central_sync)
    );

    // ****************************************************************
    // Disable logic
    // ****************************************************************
    // Local request ORed with the central one unless it is masked.
    assign disabled = clk_gate_reg[`RTCC_CG_LOCAL_DIS] |
        (central_sync & ~clk_gate_reg[`RTCC_CG_IGN_CENTRAL]);
    assign disabled_status_o = disabled;
    assign kernel_clk_en_o   = ~disabled;
    assign wr_ok             = wr_i & ~disabled;

    // Clock gate register lives on the bus clock and is always writable.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_gate_reg <= `RTCC_RST_CLK_GATE;
        end else if (wr_i && hit(addr_i, `RTCC_ADDR_CLK_GATE)) begin
            clk_gate_reg <= {12'h000, wdata_i[3:2], 1'b0, wdata_i[0]};
        end
    end

    // ****************************************************************
    // Prescaler and timer chain
    // ****************************************************************
    assign ref_rise = ref_sync & ~ref_prev_reg;
    assign pre_wrap = (pre_cnt_reg == PRE_DIV[PW-1:0] - 4'h1);
    // Without prescaler every edge steps; with it, one edge in PRE_DIV.
    assign step_in  = ref_rise & run_ctrl_reg[`RTCC_RC_RUN] & ~disabled &
        (~run_ctrl_reg[`RTCC_RC_PRESCALE] | pre_wrap);

    // Edge detect and prescale counter; restarting the divider on a mode
    // switch costs less than one timer step with prescaler (PRE_DIV-1 edges).
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_prev_reg <= 1'b0;
            pre_cnt_reg  <= {PW{1'b0}};
        end else begin
            ref_prev_reg <= ref_sync;
            if (!run_ctrl_reg[`RTCC_RC_PRESCALE] || disabled) begin
                pre_cnt_reg <= {PW{1'b0}};
            end else if (ref_rise && run_ctrl_reg[`RTCC_RC_RUN]) begin
                pre_cnt_reg <= pre_wrap ? {PW{1'b0}} : pre_cnt_reg + 4'h1;
            end
        end
    end

    // Prescale timer, count words and run control.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_ctrl_reg <= `RTCC_RST_RUN_CTRL;
            pt_reg       <= `RTCC_RST_PT;
            pt_rel_reg   <= `RTCC_RST_WORD;
            rell_reg     <= `RTCC_RST_WORD;
            relh_reg     <= `RTCC_RST_WORD;
            cnt_lo_reg   <= `RTCC_RST_WORD;
            cnt_hi_reg   <= `RTCC_RST_WORD;
            tick_reg     <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            // Timer and count stepping.
            if (run_ctrl_reg[`RTCC_RC_STEP_DOWN] && !disabled) begin
                pt_reg <= pt_reg - 16'h0001;
                run_ctrl_reg[`RTCC_RC_STEP_DOWN] <= 1'b0;
            end else if (run_ctrl_reg[`RTCC_RC_STEP_UP] && !disabled) begin
                pt_reg <= pt_reg + 16'h0001;
                run_ctrl_reg[`RTCC_RC_STEP_UP] <= 1'b0;
            end else if (step_in) begin
                if (pt_reg == 16'hFFFF) begin
                    pt_reg   <= pt_rel_reg;
                    tick_reg <= 1'b1;
                    if (cnt_lo_reg == 16'hFFFF) begin
                        cnt_lo_reg <= rell_reg;
                        cnt_hi_reg <= (cnt_hi_reg == 16'hFFFF) ? relh_reg :
                            cnt_hi_reg + 16'h0001;
                    end else begin
                        cnt_lo_reg <= cnt_lo_reg + 16'h0001;
                    end
                end else begin
                    pt_reg <= pt_reg + 16'h0001;
                end
            end
            // Register writes, blocked while disabled; a write wins.
            if (wr_ok) begin
                if (hit(addr_i, `RTCC_ADDR_RUN_CTRL)) begin
                    run_ctrl_reg <= {12'h000, wdata_i[3:0]};
                end else if (hit(addr_i, `RTCC_ADDR_PT)) begin
                    pt_reg <= wdata_i;
                end else if (hit(addr_i, `RTCC_ADDR_PT_REL)) begin
                    pt_rel_reg <= wdata_i;
                end else if (hit(addr_i, `RTCC_ADDR_RELL)) begin
                    rell_reg <= wdata_i;
                end else if (hit(addr_i, `RTCC_ADDR_RELH)) begin
                    relh_reg <= wdata_i;
                end else if (hit(addr_i, `RTCC_ADDR_CNT_LO)) begin
                    cnt_lo_reg <= wdata_i;
                end else if (hit(addr_i, `RTCC_ADDR_CNT_HI)) begin
                    cnt_hi_reg <= wdata_i;
                end
            end
        end
    end
    assign overflow_tick_irq_o = tick_reg;

    // ****************************************************************
    // Interrupt sub node
    // ****************************************************************
    // A request flag held set is not re-detected; software clears it.
    assign sn_wr = wr_ok && hit(addr_i, `RTCC_ADDR_SUBNODE);
    rtcc_subnode #(
        .NSRC (5)
    ) u_subnode (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .wr_i        (sn_wr),
        .wdata_i     (wdata_i),
        .src_pulse_i ({alarm_pulse_i, tick_reg}),
        .rdata_o     (sn_rdata),
        .irq_o       (rtc_irq_o)
    );

    // ****************************************************************
    // Read mux
    // ****************************************************************
    // Registered read data; unmapped offsets read as zero.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            if (hit(addr_i, `RTCC_ADDR_CLK_GATE)) begin
                rdata_o <= {12'h000, clk_gate_reg[3:2], disabled, clk_gate_reg[0]};
            end else if (hit(addr_i, `RTCC_ADDR_RUN_CTRL)) begin
                rdata_o <= {~disabled, 11'h000, run_ctrl_reg[3:0]};
            end else if (hit(addr_i, `RTCC_ADDR_PT)) begin
                rdata_o <= pt_reg;
            end else if (hit(addr_i, `RTCC_ADDR_PT_REL)) begin
                rdata_o <= pt_rel_reg;
            end else if (hit(addr_i, `RTCC_ADDR_RELL)) begin
                rdata_o <= rell_reg;
            end else if (hit(addr_i, `RTCC_ADDR_RELH)) begin
                rdata_o <= relh_reg;
            end else if (hit(addr_i, `RTCC_ADDR_CNT_LO)) begin
                rdata_o <= cnt_lo_reg;
            end else if (hit(addr_i, `RTCC_ADDR_CNT_HI)) begin
                rdata_o <= cnt_hi_reg;
            end else if (hit(addr_i, `RTCC_ADDR_SUBNODE)) begin
                rdata_o <= sn_rdata;
            end else begin
                rdata_o <= 16'h0000;
            end
        end
    end
endmodule // rtcc_core

/* hdl/rtcc_map.vh */
// Register offsets, field positions, reset values and timing counts for the RTC control block.
`ifndef RTCC_MAP_VH
`define RTCC_MAP_VH
// ****************************************************************
// Register offsets (16-bit peripheral register space)
// ****************************************************************
`define RTCC_ADDR_CLK_GATE   16'hF0C8
`define RTCC_ADDR_RELL       16'hF0CC
`define RTCC_ADDR_RELH       16'hF0CE
`define RTCC_ADDR_PT_REL     16'hF0D0
`define RTCC_ADDR_PT         16'hF0D2
`define RTCC_ADDR_CNT_LO     16'hF0D4
`define RTCC_ADDR_CNT_HI     16'hF0D6
`define RTCC_ADDR_SUBNODE    16'hF1C8
`define RTCC_ADDR_RUN_CTRL   16'hF1CC
// ****************************************************************
// Field positions
// ****************************************************************
`define RTCC_CG_LOCAL_DIS    0
`define RTCC_CG_DIS_STATUS   1
`define RTCC_CG_SUSPEND      2
`define RTCC_CG_IGN_CENTRAL  3
`define RTCC_RC_RUN          0
`define RTCC_RC_PRESCALE     1
`define RTCC_RC_STEP_DOWN    2
`define RTCC_RC_STEP_UP      3
`define RTCC_RC_ACCESS_OK    15
// ****************************************************************
// Reset values
// ****************************************************************
`define RTCC_RST_CLK_GATE    16'h0000
`define RTCC_RST_RUN_CTRL    16'h0003
`define RTCC_RST_PT          16'h0000
`define RTCC_RST_SUBNODE     16'h0000
`define RTCC_RST_WORD        16'h0000
// ****************************************************************
// Timing counts
// ****************************************************************
`define RTCC_PRESCALE_DIV    8
`endif

/* hdl/rtcc_sync2.v */
// Two-flip-flop synchroniser for single-bit levels entering the bus clock domain.
`timescale 1ns/1ps
module rtcc_sync2 (
    // Clock and reset.
    input  wire clk_sys_i,
    input  wire rst_n_i,
    // Asynchronous level in, synchronised level out.
    input  wire async_i,
    output wire sync_o
);
    reg stage1_reg;  // First stage, read only by the second stage.
    reg stage2_reg;  // Second stage, safe for logic.

    // Shift the level through two flip-flops.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= async_i;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_o = stage2_reg;
endmodule // rtcc_sync2

/* hdl/rtcc_subnode.v */
// Interrupt sub node: enable/request pairs merged onto one shared interrupt line.
`timescale 1ns/1ps
module rtcc_subnode #(
    parameter NSRC = 5  // Overflow source plus four alarm sources.
) (
    // Clock and reset.
    input  wire              clk_sys_i,
    input  wire              rst_n_i,
    // Software write access.
    input  wire              wr_i,
    input  wire [15:0]       wdata_i,
    // Hardware request pulses, bit 0 is the timer overflow.
    input  wire [NSRC-1:0]   src_pulse_i,
    // Register image and shared interrupt.
    output wire [15:0]       rdata_o,
    output reg               irq_o
);
    reg  [NSRC-1:0] ena_reg;  // Per-source enable bits.
    reg  [NSRC-1:0] req_reg;  // Per-source request flags.
    reg  [15:0]     img;      // Interleaved register image.
    integer         k;        // Loop index for the image builder.
    integer         j;        // Loop index for the flag update.

    // Build the interleaved image: enable at even, request at odd bits.
    always @* begin
        img = 16'h0000;
        for (k = 0; k < NSRC; k = k + 1) begin
            img[2*k]   = ena_reg[k];
            img[2*k+1] = req_reg[k];
        end
    end
    assign rdata_o = img;

    // Update enables and flags; a hardware set always beats a software clear.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ena_reg <= {NSRC{1'b0}};
            req_reg <= {NSRC{1'b0}};
            irq_o   <= 1'b0;
        end else begin
            for (j = 0; j < NSRC; j = j + 1) begin
                if (wr_i) begin
                    ena_reg[j] <= wdata_i[2*j];
                end
                if (src_pulse_i[j]) begin
                    req_reg[j] <= 1'b1;
                end else if (wr_i) begin
                    req_reg[j] <= wdata_i[2*j+1];
                end
            end
            irq_o <= |(ena_reg & req_reg);
        end
    end
endmodule // rtcc_subnode

/* tb/rtcc_core_props.sv */
// Port checker for the RTC control core, attached by bind.
`timescale 1ns/1ps
`include "rtcc_map.vh"
module rtcc_core_props #(
    parameter PRE_DIV = 8  // Prescaler factor handed on from the core.
) (
    // Clock and reset.
    input wire        clk_sys_i,
    input wire        rst_n_i,
    // Register port.
    input wire [15:0] addr_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [15:0] wdata_i,
    input wire [15:0] rdata_o,
    // Reference, requests and status.
    input wire        ref_clk_i,
    input wire        central_disable_request_i,
    input wire [3:0]  alarm_pulse_i,
    input wire        kernel_clk_en_o,
    input wire        disabled_status_o,
    input wire        overflow_tick_irq_o,
    input wire        rtc_irq_o
);
    // ****************************************************************
    // Properties, all in the bus clock domain.
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    status_mirror_a: assert property (disabled_status_o == !kernel_clk_en_o)
        else $error("clock enable and disabled status disagree");
    local_dis_a: assert property (wr_i && addr_i == `RTCC_ADDR_CLK_GATE && wdata_i[0]
        |=> disabled_status_o) else $error("local disable not honoured");
    ignore_central_a: assert property (wr_i && addr_i == `RTCC_ADDR_CLK_GATE
        && wdata_i[3:0] == 4'h8 |=> !disabled_status_o) else $error("central not masked");
    access_flag_a: assert property (rd_i && addr_i == `RTCC_ADDR_RUN_CTRL
        |=> rdata_o[15] == !$past(disabled_status_o)) else $error("access flag wrong");
    gate_read_a: assert property (rd_i && addr_i == `RTCC_ADDR_CLK_GATE |=>
        rdata_o[15:4] == 12'h000 && rdata_o[1] == $past(disabled_status_o))
        else $error("clock gate read wrong");
    node_read_a: assert property (rd_i && addr_i == `RTCC_ADDR_SUBNODE
        |=> rdata_o[15:10] == 6'h00) else $error("sub node upper bits set");
    tick_pulse_a: assert property (overflow_tick_irq_o |=> !overflow_tick_irq_o)
        else $error("tick pulse too long");
    irq_raise_a: assert property (wr_i && addr_i == `RTCC_ADDR_SUBNODE && wdata_i[1:0] == 2'h3
        && !disabled_status_o ##1 !(wr_i && addr_i == `RTCC_ADDR_SUBNODE) |=> rtc_irq_o)
        else $error("interrupt not raised");
    irq_clear_a: assert property (wr_i && addr_i == `RTCC_ADDR_SUBNODE && wdata_i[9:0] == 10'h000
        && !disabled_status_o ##1 !(wr_i && addr_i == `RTCC_ADDR_SUBNODE) |=> !rtc_irq_o)
        else $error("interrupt not cleared");
    tick_seen_c: cover property (overflow_tick_irq_o);
    irq_seen_c: cover property ($rose(rtc_irq_o));
    dis_seen_c: cover property ($rose(disabled_status_o));
endmodule // rtcc_core_props
bind rtcc_core rtcc_core_props #(.PRE_DIV(PRE_DIV)) u_props (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .ref_clk_i(ref_clk_i),
    .central_disable_request_i(central_disable_request_i), .alarm_pulse_i(alarm_pulse_i),
    .kernel_clk_en_o(kernel_clk_en_o), .disabled_status_o(disabled_status_o),
    .overflow_tick_irq_o(overflow_tick_irq_o), .rtc_irq_o(rtc_irq_o));

/* tb/rtcc_ref_model.sv */
// Reference clock source that feeds the RTC count input.
`timescale 1ns/1ps
module rtcc_ref_model #(
    parameter HALF = 5  // Bus clock cycles per half period.
) (
    // Bus clock and run control.
    input  wire clk_sys_i,
    input  wire run_i,
    // Reference clock out.
    output reg  ref_clk_o
);
    integer cnt = 0;  // Cycles in the current half period.
    initial ref_clk_o = 1'b0;
    // The source stands low while idle, so no stray edge reaches the timer.
    always @(posedge clk_sys_i) begin
        if (!run_i) begin
            cnt <= 0;
            ref_clk_o <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            ref_clk_o <= !ref_clk_o;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // rtcc_ref_model

/* tb/tb_top.sv */
// Self-checking testbench for the RTC control core.
`timescale 1ns/1ps
`include "rtcc_map.vh"
module tb_top;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, ref_run = 1'b0;
    logic [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, rdata_o;
    logic central_disable_request_i = 1'b0, ref_clk_i;
    logic [3:0] alarm_pulse_i = 4'h0;
    logic kernel_clk_en_o, disabled_status_o, overflow_tick_irq_o, rtc_irq_o;
    logic pend1 = 1'b0, pend2 = 1'b0;          // Read pipeline trackers.
    logic [15:0] ticks = 16'h0000, edges = 16'h0000, n, rv, en;
    logic [15:0] exp_q[$];                     // Expected read words.
    integer fails = 0, tests_run = 0, cyc = 0, k;
    always #20 clk_sys_i = !clk_sys_i;
    rtcc_core uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i),
        .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .ref_clk_i(ref_clk_i),
        .central_disable_request_i(central_disable_request_i), .alarm_pulse_i(alarm_pulse_i),
        .kernel_clk_en_o(kernel_clk_en_o), .disabled_status_o(disabled_status_o),
        .overflow_tick_irq_o(overflow_tick_irq_o), .rtc_irq_o(rtc_irq_o));
    rtcc_ref_model u_ref (.clk_sys_i(clk_sys_i), .run_i(ref_run), .ref_clk_o(ref_clk_i));
    // ****************************************************************
    // Compare, bus and closing tasks.
    // ****************************************************************
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] e);
        tests_run++;
        if (got !== e) begin
            fails++;
            $display("mismatch at %0t: word %h expected %h", $time, got, e);
        end
    endtask
    // Flags are captured when the task is called, at the clock edge; the compare waits for the next negedge.
    task automatic chk(input logic got, input logic e);
        @(negedge clk_sys_i);
        cmp_word({15'h0000, got}, {15'h0000, e});
        @(posedge clk_sys_i);
    endtask
    // A write holds one cycle, then two idle cycles let its effect land.
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [3:0] p);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        alarm_pulse_i <= p;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        alarm_pulse_i <= 4'h0;
        repeat (2) @(posedge clk_sys_i);
    endtask
    // A read notes its expected word; the monitor compares when data arrives.
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    // Waits a bounded time for the next overflow tick.
    task automatic wait_tick();
        n = ticks;
        for (int i = 0; i < 400 && ticks == n; i++) @(posedge clk_sys_i);
        if (ticks == n) cmp_word(16'hDEAD, 16'h0000);
    endtask
    task automatic conclude();
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // Monitor and timeout.
    // ****************************************************************
    always @(posedge clk_sys_i) begin
        pend1 <= rd_i;
        pend2 <= pend1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    always @(negedge clk_sys_i) begin
        if (pend2) cmp_word(rdata_o, exp_q.pop_front());
        if (overflow_tick_irq_o === 1'b1) ticks <= ticks + 16'h0001;
    end
    always @(posedge ref_clk_i) edges <= edges + 16'h0001;
    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        rv = $urandom(43506);
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(`RTCC_ADDR_RUN_CTRL, 16'h8003);
        rd(`RTCC_ADDR_CLK_GATE, 16'h0000);
        rd(`RTCC_ADDR_SUBNODE, 16'h0000);
        rd(`RTCC_ADDR_PT, 16'h0000);
        rd(16'hF0C0, 16'h0000);
        // Single steps on a stopped timer; with both set, down runs first, then up.
        wr(`RTCC_ADDR_RUN_CTRL, 16'h0000, 4'h0);
        wr(`RTCC_ADDR_PT, 16'hFFFE, 4'h0);
        wr(`RTCC_ADDR_RUN_CTRL, 16'h0008, 4'h0);
        rd(`RTCC_ADDR_PT, 16'hFFFF);
        rd(`RTCC_ADDR_RUN_CTRL, 16'h8000);
        wr(`RTCC_ADDR_RUN_CTRL, 16'h0004, 4'h0);
        rd(`RTCC_ADDR_PT, 16'hFFFE);
        wr(`RTCC_ADDR_RUN_CTRL, 16'h000C, 4'h0);
        rd(`RTCC_ADDR_PT, 16'hFFFE);
        // Overflow reloads, advances the count and raises the shared line.
        wr(`RTCC_ADDR_PT_REL, 16'h1234, 4'h0);
        wr(`RTCC_ADDR_CNT_LO, 16'h0005, 4'h0);
        wr(`RTCC_ADDR_SUBNODE, 16'h0001, 4'h0);
        wr(`RTCC_ADDR_RUN_CTRL, 16'h0001, 4'h0);
        ref_run <= 1'b1;
        wait_tick();
        ref_run <= 1'b0;
        wr(`RTCC_ADDR_RUN_CTRL, 16'h0000, 4'h0);
        rd(`RTCC_ADDR_CNT_LO, 16'h0006);
        rd(`RTCC_ADDR_SUBNODE, 16'h0003);
        chk(rtc_irq_o, 1'b1);
        wr(`RTCC_ADDR_SUBNODE, 16'h0001, 4'h0);
        chk(rtc_irq_o, 1'b0);
        wr(`RTCC_ADDR_SUBNODE, 16'h0003, 4'h0);
        chk(rtc_irq_o, 1'b1);
        // Each alarm pulses alongside the write that enables it.
        for (k = 0; k < 4; k++) begin
            en = 16'h0004 << (2 * k);
            wr(`RTCC_ADDR_SUBNODE, en, 4'h1 << k);
            rd(`RTCC_ADDR_SUBNODE, en | (en << 1));
            chk(rtc_irq_o, 1'b1);
            wr(`RTCC_ADDR_SUBNODE, 16'h0000, 4'h0);
            chk(rtc_irq_o, 1'b0);
        end
        // Random words through the reload and count registers.
        rv = $urandom;
        wr(`RTCC_ADDR_CNT_HI, rv, 4'h0);
        rd(`RTCC_ADDR_CNT_HI, rv);
        wr(`RTCC_ADDR_PT_REL, ~rv, 4'h0);
        rd(`RTCC_ADDR_PT_REL, ~rv);
        // Local disable blocks writes but keeps the gate register live.
        wr(`RTCC_ADDR_CLK_GATE, 16'h0001, 4'h0);
        chk(kernel_clk_en_o, 1'b0);
        rd(`RTCC_ADDR_CLK_GATE, 16'h0003);
        rd(`RTCC_ADDR_RUN_CTRL, 16'h0000);
        wr(`RTCC_ADDR_PT_REL, rv, 4'h0);
        rd(`RTCC_ADDR_PT_REL, ~rv);
        wr(`RTCC_ADDR_CLK_GATE, 16'h0000, 4'h0);
        chk(disabled_status_o, 1'b0);
        // Central request, and the bit that masks it.
        central_disable_request_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        chk(disabled_status_o, 1'b1);
        wr(`RTCC_ADDR_CLK_GATE, 16'h0008, 4'h0);
        chk(disabled_status_o, 1'b0);
        wr(`RTCC_ADDR_CLK_GATE, 16'h0000, 4'h0);
        chk(disabled_status_o, 1'b1);
        central_disable_request_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        chk(disabled_status_o, 1'b0);
        // Reference edges between ticks, with and without the prescaler.
        wr(`RTCC_ADDR_PT_REL, 16'hFFFF, 4'h0);
        wr(`RTCC_ADDR_PT, 16'hFFFF, 4'h0);
        for (k = 0; k < 2; k++) begin
            wr(`RTCC_ADDR_RUN_CTRL, (k == 1) ? 16'h0003 : 16'h0001, 4'h0);
            ref_run <= 1'b1;
            wait_tick();
            rv = edges;
            wait_tick();
            cmp_word(edges - rv, (k == 1) ? `RTCC_PRESCALE_DIV : 1);
            ref_run <= 1'b0;
        end
        // A stopped timer ignores the reference clock.
        wr(`RTCC_ADDR_RUN_CTRL, 16'h0000, 4'h0);
        ref_run <= 1'b1;
        rv = ticks;
        repeat (200) @(posedge clk_sys_i);
        cmp_word(ticks - rv, 16'h0000);
        repeat (4) @(posedge clk_sys_i);
        conclude();
    end
endmodule // tb_top
